// ==== ipc_core_ctrl.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Two-way 16 KiB cache, 32-byte burst fills.
// RL2: Cache flushes only on fetch fence.
// RL3: Fetch from non-executable region traps.
// RL4: Target buffer, history table, return stack predict.
// RL5: Good prediction free; misprediction costs three.
// RL6: Single in-order issue, full bypass.
// RL7: Word load two, sub-word and CSR three.
// RL8: Multiply results arrive after five cycles.
// RL9: Divide takes two to thirty-three cycles.
// RL10: Stall on RAW and WAW hazards, a busy multiply or divide unit, a pending penalty, or a full store queue.
// RL11: One multiply or divide at once.
// RL12: Divide never cancelled; dependents wait.
// RL13: Branches redirect from memory stage.
// RL14: CSR writes flush, costing five cycles.
// RL15: Data RAM word two, smaller three.
// RL16: Misaligned accesses trap.
// RL17: Stores commit when idle; queue hit costs five.
// RL18: Atomics off supported regions raise access fault.
// RL19: Reserved pairs fault on uncached or data RAM.
// RL20: 64-bit cycle and retired counters, split halves.
// RL21: First fetch from 0x1000 after reset.
// RL22: Vector resets zero; address zero reads zero.
module ipc_core_ctrl #(
  parameter int SQ_DEPTH = 2
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic            ins_valid,
  input  wire ipc_pkg::ipc_op_e ins_op,
  input  wire logic [4:0]      ins_rd,
  input  wire logic [4:0]      ins_rs1,
  input  wire logic [4:0]      ins_rs2,
  input  wire logic [1:0]      ins_size,
  input  wire logic [31:0]     ins_opnd,
  input  wire logic [11:0]     ins_csr,
  input  wire logic            irq,
  input  wire logic            br_resolve,
  input  wire logic            br_mispredict,
  input  wire logic            br_cond,
  input  wire logic            br_taken,
  input  wire logic [31:0]     br_pc,
  input  wire logic [31:0]     br_target,
  input  wire logic            fetch_take,
  input  wire logic            fetch_hit,
  input  wire logic            pred_cond,
  input  wire logic            pred_call,
  input  wire logic            pred_ret,
  input  wire logic            btb_hit,
  input  wire logic [31:0]     btb_target,
  input  wire logic            fill_valid,
  output logic                 ins_ready,
  output logic                 issue_fire,
  output logic                 trap,
  output logic [4:0]           trap_cause,
  output logic [31:0]          fetch_addr,
  output logic                 fetch_zero,
  output logic                 icache_flush,
  output logic                 fill_req,
  output logic [31:0]          fill_addr,
  output logic                 store_commit,
  output logic [31:0]          store_addr,
  output logic [31:0]          csr_rdata
);
  typedef struct packed {
    logic [31:0]                 pc;
    logic [31:0]                 tvec;
    logic [ipc_pkg::NREG-1:0][5:0] sb;
    logic [2:0]                  mbusy;
    logic [5:0]                  dbusy;
    logic [2:0]                  pen;
    logic                        d_vld;
    ipc_pkg::ipc_op_e            d_op;
    logic [4:0]                  d_rd;
    logic [4:0]                  d_rs1;
    logic [4:0]                  d_rs2;
    logic [1:0]                  d_size;
    logic [31:0]                 d_opnd;
    logic [11:0]                 d_csr;
    logic [SQ_DEPTH-1:0][31:0]   sq_a;
    logic [SQ_DEPTH-1:0]         sq_v;
    logic [ipc_pkg::BHT_ENTRIES-1:0][1:0] bht;
    logic [ipc_pkg::RAS_ENTRIES-1:0][31:0] ras;
    ipc_pkg::ipc_fill_e          fst;
    logic [3:0]                  beat;
    logic [63:0]                 cyc;
    logic [63:0]                 ret;
    logic                        rdy;
    logic                        fire;
    logic                        trap;
    logic [4:0]                  cause;
    logic                        zero;
    logic                        flush;
    logic                        freq;
    logic [31:0]                 fa;
    logic                        commit;
    logic [31:0]                 ca;
    logic [31:0]                 csr_q;
  } ipc_state_s;

  ipc_state_s s_reg;
  ipc_state_s s_next;

  function automatic logic in_f(input logic [31:0] a, input logic [31:0] b,
                                input logic [31:0] t);
    in_f = (a >= b) && (a <= t);
  endfunction

  // Regions that hold code; all of them are also cacheable.
  function automatic logic exec_f(input logic [31:0] a);
    exec_f = in_f(a, ipc_pkg::DBG_BASE, ipc_pkg::DBG_TOP)
          || in_f(a, ipc_pkg::ROM_BASE, ipc_pkg::ROM_TOP)
          || in_f(a, ipc_pkg::OTP_BASE, ipc_pkg::OTP_TOP)
          || in_f(a, ipc_pkg::FLASH_BASE, ipc_pkg::FLASH_TOP)
          || in_f(a, ipc_pkg::TCDR_BASE, ipc_pkg::TCDR_TOP);
  endfunction

  function automatic logic tcdr_f(input logic [31:0] a);
    tcdr_f = in_f(a, ipc_pkg::TCDR_BASE, ipc_pkg::TCDR_TOP);
  endfunction

  function automatic logic sq_hit_f(input ipc_state_s x);
    sq_hit_f = 1'b0;
    for (int i = 0; i < SQ_DEPTH; i++) begin
      if (x.sq_v[i] && (x.sq_a[i][31:2] == x.d_opnd[31:2])) sq_hit_f = 1'b1;
    end
  endfunction

  // Divide time grows with the dividend's significant bits, one per cycle.
  function automatic logic [5:0] div_len_f(input logic [31:0] a);
    div_len_f = ipc_pkg::DIV_MIN;
    for (int i = 0; i < 32; i++) begin
      if (a[i]) div_len_f = 6'(i) + ipc_pkg::DIV_MIN;
    end
  endfunction

  function automatic logic [5:0] lat_f(input ipc_state_s x);
    unique case (x.d_op)
      ipc_pkg::OP_LOAD: begin
        lat_f = (x.d_size == ipc_pkg::SZ_WORD) ? ipc_pkg::LAT_WORD : ipc_pkg::LAT_SUB; // [RL7] [RL15]
        if (sq_hit_f(x)) lat_f = lat_f + ipc_pkg::SQ_HIT_PEN; // [RL17]
      end
      ipc_pkg::OP_AMO, ipc_pkg::OP_LR, ipc_pkg::OP_SC: lat_f = ipc_pkg::LAT_WORD;
      ipc_pkg::OP_CSRR, ipc_pkg::OP_CSRW: lat_f = ipc_pkg::LAT_CSR; // [RL7]
      ipc_pkg::OP_MUL: lat_f = ipc_pkg::LAT_MUL; // [RL8]
      ipc_pkg::OP_DIV: lat_f = div_len_f(x.d_opnd); // [RL9]
      default: lat_f = ipc_pkg::LAT_ALU; // [RL6]
    endcase
  endfunction

  // Returns {valid, cause} for the instruction held in decode.
  function automatic logic [5:0] trap_f(input ipc_state_s x);
    logic mis;
    logic ld;
    logic mem;
    mis = (x.d_size == ipc_pkg::SZ_WORD) ? (x.d_opnd[1:0] != 2'h0)
        : ((x.d_size == ipc_pkg::SZ_HALF) && x.d_opnd[0]);
    ld  = (x.d_op == ipc_pkg::OP_LOAD) || (x.d_op == ipc_pkg::OP_LR);
    mem = (x.d_op == ipc_pkg::OP_LOAD) || (x.d_op == ipc_pkg::OP_STORE);
    if (!mem && (x.d_op inside {ipc_pkg::OP_AMO, ipc_pkg::OP_LR, ipc_pkg::OP_SC})) begin
      mis = x.d_opnd[1:0] != 2'h0;
    end
    trap_f = 6'h00;
    if ((mem || x.d_op inside {ipc_pkg::OP_AMO, ipc_pkg::OP_LR, ipc_pkg::OP_SC}) && mis) begin
      trap_f = {1'b1, ld ? ipc_pkg::CAUSE_LD_MIS : ipc_pkg::CAUSE_ST_MIS}; // [RL16]
    end else if (x.d_op == ipc_pkg::OP_AMO && !(exec_f(x.d_opnd)
                 || in_f(x.d_opnd, ipc_pkg::PER_BASE, ipc_pkg::PER_TOP))) begin
      trap_f = {1'b1, ipc_pkg::CAUSE_ST_ACC}; // [RL18]
    end else if ((x.d_op inside {ipc_pkg::OP_LR, ipc_pkg::OP_SC})
                 && (!exec_f(x.d_opnd) || tcdr_f(x.d_opnd))) begin
      trap_f = {1'b1, ld ? ipc_pkg::CAUSE_LD_ACC : ipc_pkg::CAUSE_ST_ACC}; // [RL19]
    end
  endfunction

  // Issue leaves decode only when no register or unit hazard stands.
  function automatic logic go_f(input ipc_state_s x);
    logic haz;
    logic mblk;
    haz  = (x.sb[x.d_rs1] != 6'h00) || (x.sb[x.d_rs2] != 6'h00)
        || (x.sb[x.d_rd] != 6'h00); // [RL10] [RL12]
    mblk = (x.d_op inside {ipc_pkg::OP_MUL, ipc_pkg::OP_DIV})
        && ((x.mbusy != 3'h0) || (x.dbusy != 6'h00)); // [RL11]
    go_f = x.d_vld && (x.pen == 3'h0) && !haz && !mblk
        && !(x.d_op == ipc_pkg::OP_STORE && x.sq_v[SQ_DEPTH-1]);
  endfunction

  logic       kill;
  logic       go;
  logic [5:0] tr;
  logic       memuse;
  logic       pfault;
  logic       drop;
  logic       placed;
  logic [31:0] nxt;
  logic [ipc_pkg::BHT_BITS-1:0] bi;

  // One combinational pass computes the whole next state.
  always_comb begin
    s_next = s_reg;
    placed = 1'b0;
    kill   = br_resolve && br_mispredict;
    go     = go_f(s_reg) && !kill;
    tr     = trap_f(s_reg);
    memuse = go && (s_reg.d_op inside {ipc_pkg::OP_LOAD, ipc_pkg::OP_AMO,
                                       ipc_pkg::OP_LR, ipc_pkg::OP_SC});
    pfault = !exec_f(s_reg.pc) && (s_reg.pc > ipc_pkg::ZERO_TOP) && (s_reg.pen == 3'h0);
    drop   = kill;
    nxt    = s_reg.pc + ipc_pkg::PC_STEP;
    bi     = s_reg.pc[ipc_pkg::BHT_LSB +: ipc_pkg::BHT_BITS];
    s_next.fire   = 1'b0;
    s_next.trap   = 1'b0;
    s_next.flush  = 1'b0;
    s_next.freq   = 1'b0;
    s_next.commit = 1'b0;
    s_next.cyc    = s_reg.cyc + 64'h0000_0000_0000_0001; // [RL20]
    // Scoreboard and unit countdowns run on regardless of flushes, so a divide always completes.
    for (int i = 0; i < ipc_pkg::NREG; i++) begin
      if (s_reg.sb[i] != 6'h00) s_next.sb[i] = s_reg.sb[i] - 6'h01; // [RL6] [RL12]
    end
    if (s_reg.mbusy != 3'h0) s_next.mbusy = s_reg.mbusy - 3'h1;
    if (s_reg.dbusy != 6'h00) s_next.dbusy = s_reg.dbusy - 6'h01; // [RL12]
    if (s_reg.pen != 3'h0) s_next.pen = s_reg.pen - 3'h1;
    // Queued stores drain only in cycles when no load, AMO, LR or SC issues.
    if (s_reg.sq_v[0] && !memuse) begin
      s_next.commit = 1'b1; // [RL17]
      s_next.ca     = s_reg.sq_a[0];
      for (int i = 0; i < SQ_DEPTH - 1; i++) begin
        s_next.sq_a[i] = s_reg.sq_a[i + 1];
        s_next.sq_v[i] = s_reg.sq_v[i + 1];
      end
      s_next.sq_v[SQ_DEPTH-1] = 1'b0;
    end
    if (go) begin
      s_next.d_vld = 1'b0;
      if (tr[5]) begin
        s_next.trap  = 1'b1;
        s_next.cause = tr[4:0];
        drop         = 1'b1;
      end else begin
        s_next.fire = 1'b1;
        s_next.ret  = s_reg.ret + 64'h0000_0000_0000_0001; // [RL20]
        if (s_reg.d_rd != 5'h00) s_next.sb[s_reg.d_rd] = lat_f(s_reg) - 6'h01;
        unique case (s_reg.d_op)
          ipc_pkg::OP_MUL: s_next.mbusy = ipc_pkg::MUL_BUSY; // [RL11]
          ipc_pkg::OP_DIV: s_next.dbusy = div_len_f(s_reg.d_opnd) - 6'h01; // [RL9]
          ipc_pkg::OP_FENCEI: s_next.flush = 1'b1; // [RL2]
          ipc_pkg::OP_CSRW: begin
            s_next.pen = ipc_pkg::CSR_FLUSH_PEN; // [RL14]
            if (s_reg.d_csr == ipc_pkg::CSR_TVEC) s_next.tvec = s_reg.d_opnd;
          end
          ipc_pkg::OP_STORE: begin
            for (int i = 0; i < SQ_DEPTH; i++) begin
              if (!s_next.sq_v[i] && !placed) begin
                s_next.sq_v[i] = 1'b1; // [RL17]
                s_next.sq_a[i] = s_reg.d_opnd;
                placed         = 1'b1;
              end
            end
          end
          default: ;
        endcase
        unique case (s_reg.d_csr)
          ipc_pkg::CSR_CYC:  s_next.csr_q = s_reg.cyc[31:0]; // [RL20]
          ipc_pkg::CSR_CYCH: s_next.csr_q = s_reg.cyc[63:32];
          ipc_pkg::CSR_RET:  s_next.csr_q = s_reg.ret[31:0];
          ipc_pkg::CSR_RETH: s_next.csr_q = s_reg.ret[63:32];
          ipc_pkg::CSR_TVEC: s_next.csr_q = s_reg.tvec;
          default:           s_next.csr_q = 32'h0000_0000;
        endcase
      end
    end else if (irq && !kill) begin
      s_next.trap  = 1'b1;
      s_next.cause = ipc_pkg::CAUSE_IRQ;
      s_next.d_vld = 1'b0;
      drop         = 1'b1;
    end else if (pfault && !kill) begin
      s_next.trap  = 1'b1; // [RL3]
      s_next.cause = ipc_pkg::CAUSE_FETCH;
      drop         = 1'b1;
    end
    // Fetch steering: prediction adds no bubble when it is right.
    if (pred_ret) begin
      nxt           = s_reg.ras[0]; // [RL4] [RL5]
      s_next.ras[0] = s_reg.ras[1];
    end else if (btb_hit && (!pred_cond || s_reg.bht[bi][1])) begin
      nxt = btb_target; // [RL4]
    end
    if (pred_call) begin
      s_next.ras[1] = s_reg.ras[0];
      s_next.ras[0] = s_reg.pc + ipc_pkg::PC_STEP;
    end
    if (fetch_take && fetch_hit && s_reg.fst == ipc_pkg::FILL_IDLE && !pfault) begin
      s_next.pc = nxt;
    end
    // A miss starts one line burst; the memory answers a beat per cycle.
    unique case (s_reg.fst)
      // Only executable space is filled, even while a penalty still hides the fetch fault.
      ipc_pkg::FILL_IDLE: if (!fetch_hit && exec_f(s_reg.pc)) begin
        s_next.fst  = ipc_pkg::FILL_BURST; // [RL1]
        s_next.freq = 1'b1;
        s_next.fa   = {s_reg.pc[31:$clog2(ipc_pkg::LINE_BYTES)],
                       {$clog2(ipc_pkg::LINE_BYTES){1'b0}}};
        s_next.beat = 4'h0;
      end
      ipc_pkg::FILL_BURST: if (fill_valid) begin
        s_next.beat = s_reg.beat + 4'h1;
        if (s_reg.beat == 4'(ipc_pkg::LINE_BEATS - 1)) s_next.fst = ipc_pkg::FILL_IDLE;
      end
    endcase
    // Predictor training from the branch outcome.
    if (br_resolve && br_cond) begin
      if (br_taken && s_reg.bht[br_pc[ipc_pkg::BHT_LSB +: ipc_pkg::BHT_BITS]] != 2'h3) begin
        s_next.bht[br_pc[ipc_pkg::BHT_LSB +: ipc_pkg::BHT_BITS]] =
          s_reg.bht[br_pc[ipc_pkg::BHT_LSB +: ipc_pkg::BHT_BITS]] + 2'h1;
      end else if (!br_taken && s_reg.bht[br_pc[ipc_pkg::BHT_LSB +: ipc_pkg::BHT_BITS]] != 2'h0) begin
        s_next.bht[br_pc[ipc_pkg::BHT_LSB +: ipc_pkg::BHT_BITS]] =
          s_reg.bht[br_pc[ipc_pkg::BHT_LSB +: ipc_pkg::BHT_BITS]] - 2'h1;
      end
    end
    // Redirects: a resolved misprediction is older than anything else here.
    if (kill) begin
      s_next.pc    = br_target; // [RL13]
      s_next.pen   = ipc_pkg::MISPRED_PEN; // [RL5]
      s_next.d_vld = 1'b0;
      s_next.fst   = ipc_pkg::FILL_IDLE;
      s_next.freq  = 1'b0;
    end else if (s_next.trap) begin
      s_next.pc  = s_reg.tvec; // [RL22]
      s_next.pen = ipc_pkg::MISPRED_PEN;
      s_next.fst = ipc_pkg::FILL_IDLE;
      s_next.freq = 1'b0;
    end
    if (ins_valid && s_reg.rdy && !drop) begin
      s_next.d_vld  = 1'b1;
      s_next.d_op   = ins_op;
      s_next.d_rd   = ins_rd;
      s_next.d_rs1  = ins_rs1;
      s_next.d_rs2  = ins_rs2;
      s_next.d_size = ins_size;
      s_next.d_opnd = ins_opnd;
      s_next.d_csr  = ins_csr;
    end
    // Ready looks one cycle ahead so back-to-back issue keeps one per cycle.
    s_next.zero = s_next.pc <= ipc_pkg::ZERO_TOP; // [RL22]
    s_next.rdy  = !s_next.d_vld || go_f(s_next); // [RL6]
  end

  // Clock enable low freezes every bit of state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg      <= '0;
      s_reg.pc   <= ipc_pkg::RESET_PC; // [RL21]
      s_reg.tvec <= ipc_pkg::TVEC_RESET; // [RL22]
      s_reg.rdy  <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign ins_ready    = s_reg.rdy;
  assign issue_fire   = s_reg.fire;
  assign trap         = s_reg.trap;
  assign trap_cause   = s_reg.cause;
  assign fetch_addr   = s_reg.pc;
  assign fetch_zero   = s_reg.zero;
  assign icache_flush = s_reg.flush;
  assign fill_req     = s_reg.freq;
  assign fill_addr    = s_reg.fa;
  assign store_commit = s_reg.commit;
  assign store_addr   = s_reg.ca;
  assign csr_rdata    = s_reg.csr_q;

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  AST_RESET_VEC: assert property ($fell(rst) |-> fetch_addr == ipc_pkg::RESET_PC && s_reg.tvec == 32'h0000_0000) // [RL21]
    else $error("Reset vector wrong.");
  AST_MISPRED: assert property (ce && kill |=> s_reg.pen == ipc_pkg::MISPRED_PEN && !s_reg.d_vld && fetch_addr == $past(br_target)) // [RL5]
    else $error("Mispredict penalty or redirect wrong.");
  AST_CSR_FLUSH: assert property (ce && go && !tr[5] && s_reg.d_op == ipc_pkg::OP_CSRW |=> s_reg.pen == ipc_pkg::CSR_FLUSH_PEN) // [RL14]
    else $error("CSR write did not flush.");
  AST_MUL_LAT: assert property (ce && go && !tr[5] && s_reg.d_op == ipc_pkg::OP_MUL && s_reg.d_rd != 5'h00 |=> s_reg.sb[$past(s_reg.d_rd)] == 6'h04) // [RL8]
    else $error("Multiply latency wrong.");
  AST_RAW_STALL: assert property (ce && s_reg.d_vld && s_reg.sb[s_reg.d_rs1] > 6'h01 |=> !issue_fire) // [RL10]
    else $error("Issued across a hazard.");
  AST_MISALIGN: assert property (ce && go && s_reg.d_op == ipc_pkg::OP_LOAD && s_reg.d_size == ipc_pkg::SZ_WORD && s_reg.d_opnd[1:0] != 2'h0 |=> trap && trap_cause == ipc_pkg::CAUSE_LD_MIS) // [RL16]
    else $error("Misaligned load did not trap.");
  AST_LR_TCDR: assert property (ce && go && s_reg.d_op == ipc_pkg::OP_LR && s_reg.d_opnd[1:0] == 2'h0 && tcdr_f(s_reg.d_opnd) |=> trap && trap_cause == ipc_pkg::CAUSE_LD_ACC) // [RL19]
    else $error("Reserved load on data RAM did not fault.");
  AST_CYCLES: assert property (ce |=> s_reg.cyc == $past(s_reg.cyc) + 64'h0000_0000_0000_0001) // [RL20]
    else $error("Cycle counter did not advance.");
  AST_DIV_KEEP: assert property (ce && s_reg.dbusy != 6'h00 && (irq || kill) |=> s_reg.dbusy == $past(s_reg.dbusy) - 6'h01) // [RL12]
    else $error("Divide was cancelled.");
  AST_FILL_LINE: assert property (fill_req |-> fill_addr[4:0] == 5'h00 && s_reg.fst == ipc_pkg::FILL_BURST) // [RL1]
    else $error("Fill burst not line aligned.");
  AST_FETCH_FAULT: assert property (ce && pfault && !go && !irq && !kill |=> trap && trap_cause == ipc_pkg::CAUSE_FETCH && fetch_addr == $past(s_reg.tvec)) // [RL3]
    else $error("Non-executable fetch not trapped.");
  AST_SQ_HIT: assert property (ce && go && !tr[5] && s_reg.d_op == ipc_pkg::OP_LOAD && sq_hit_f(s_reg) && s_reg.d_rd != 5'h00 |=> s_reg.sb[$past(s_reg.d_rd)] >= 6'h06) // [RL17]
    else $error("Store queue hit penalty missing.");
endmodule

// ==== ipc_pkg.sv ====
package ipc_pkg;
  // Core geometry and predictor sizes.
  localparam int          NREG         = 32;
  localparam int          ICACHE_BYTES = 16384;
  localparam int          ICACHE_WAYS  = 2;
  localparam int          LINE_BYTES   = 32;
  localparam int          LINE_BEATS   = LINE_BYTES / 4;
  localparam int          BTB_ENTRIES  = 40;
  localparam int          BHT_ENTRIES  = 128;
  localparam int          BHT_BITS     = $clog2(BHT_ENTRIES);
  localparam int          BHT_LSB      = 2;
  localparam int          RAS_ENTRIES  = 2;
  localparam int          MUL_BITS     = 8;
  localparam int          DIV_BITS     = 1;
  // Reset values and the fetch step.
  localparam logic [31:0] RESET_PC     = 32'h0000_1000;
  localparam logic [31:0] TVEC_RESET   = 32'h0000_0000;
  localparam logic [31:0] PC_STEP      = 32'h0000_0004;
  // Penalties and result latencies in cycles.
  localparam logic [2:0]  MISPRED_PEN  = 3'h3;
  localparam logic [2:0]  CSR_FLUSH_PEN = 3'h5;
  localparam logic [5:0]  SQ_HIT_PEN   = 6'h05;
  localparam logic [5:0]  LAT_ALU      = 6'h01;
  localparam logic [5:0]  LAT_WORD     = 6'h02;
  localparam logic [5:0]  LAT_SUB      = 6'h03;
  localparam logic [5:0]  LAT_CSR      = 6'h03;
  localparam logic [5:0]  LAT_MUL      = 6'h05;
  localparam logic [5:0]  DIV_MIN      = 6'h02;
  localparam logic [5:0]  DIV_MAX      = 6'h21;
  localparam logic [2:0]  MUL_BUSY     = 3'(32 / MUL_BITS - 1);
  // Address regions.
  localparam logic [31:0] ZERO_TOP     = 32'h0000_00ff;
  localparam logic [31:0] DBG_BASE     = 32'h0000_0100;
  localparam logic [31:0] DBG_TOP      = 32'h0000_0fff;
  localparam logic [31:0] ROM_BASE     = 32'h0000_1000;
  localparam logic [31:0] ROM_TOP      = 32'h0000_1fff;
  localparam logic [31:0] OTP_BASE     = 32'h0002_0000;
  localparam logic [31:0] OTP_TOP      = 32'h0002_1fff;
  localparam logic [31:0] PER_BASE     = 32'h0200_0000;
  localparam logic [31:0] PER_TOP      = 32'h1fff_ffff;
  localparam logic [31:0] FLASH_BASE   = 32'h2000_0000;
  localparam logic [31:0] FLASH_TOP    = 32'h3fff_ffff;
  localparam logic [31:0] TCDR_BASE    = 32'h8000_0000;
  localparam logic [31:0] TCDR_TOP     = 32'h8000_3fff;
  // Counter and vector CSR numbers.
  localparam logic [11:0] CSR_TVEC     = 12'h305;
  localparam logic [11:0] CSR_CYC      = 12'hb00;
  localparam logic [11:0] CSR_RET      = 12'hb02;
  localparam logic [11:0] CSR_CYCH     = 12'hb80;
  localparam logic [11:0] CSR_RETH     = 12'hb82;
  // Trap causes.
  localparam logic [4:0]  CAUSE_FETCH  = 5'h01;
  localparam logic [4:0]  CAUSE_LD_MIS = 5'h04;
  localparam logic [4:0]  CAUSE_LD_ACC = 5'h05;
  localparam logic [4:0]  CAUSE_ST_MIS = 5'h06;
  localparam logic [4:0]  CAUSE_ST_ACC = 5'h07;
  localparam logic [4:0]  CAUSE_IRQ    = 5'h1f;
  // Access sizes.
  localparam logic [1:0]  SZ_HALF      = 2'h1;
  localparam logic [1:0]  SZ_WORD      = 2'h2;

  typedef enum logic [3:0] {
    OP_ALU, OP_BR, OP_LOAD, OP_STORE, OP_CSRR, OP_CSRW,
    OP_MUL, OP_DIV, OP_AMO, OP_LR, OP_SC, OP_FENCEI
  } ipc_op_e;

  typedef enum logic {FILL_IDLE = 1'b0, FILL_BURST = 1'b1} ipc_fill_e;
endpackage

// ==== ipc_imem_model.sv ====
`timescale 1ns/1ps
// Instruction memory beside the core: a line fill is answered by eight beats.
// The beats start one cycle after the request, which is the one-cycle access latency.
module ipc_imem_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic fill_req,
  output logic      fill_valid
);
  logic [3:0] beats_reg;
  // A new request restarts the burst, so a repeated request is never lost.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      beats_reg <= 4'h0;
    end else if (fill_req) begin
      beats_reg <= 4'h8;
    end else if (beats_reg != 4'h0) begin
      beats_reg <= beats_reg - 4'h1;
    end
  end
  assign fill_valid = (beats_reg != 4'h0);
endmodule

// ==== inorder_core_pipeline_bench.sv ====
`timescale 1ns/1ps
module inorder_core_pipeline_bench;
  logic             clk, rst, ce, ins_valid, irq, br_resolve, br_mispredict, br_cond;
  logic             br_taken, fetch_take, fetch_hit, pred_cond, pred_call, pred_ret;
  logic             btb_hit, fill_valid, ins_ready, issue_fire, trap, fetch_zero;
  logic             icache_flush, fill_req, store_commit;
  ipc_pkg::ipc_op_e ins_op;
  logic [4:0]       ins_rd, ins_rs1, ins_rs2, trap_cause;
  logic [1:0]       ins_size;
  logic [11:0]      ins_csr;
  logic [31:0]      ins_opnd, br_pc, br_target, btb_target, fetch_addr, fill_addr;
  logic [31:0]      store_addr, csr_rdata, v1;
  int               n_fail, cmp_count, cyc, n_trap, n_flush, n_fill, fires[$];

  ipc_core_ctrl dut (.clk, .rst, .ce, .ins_valid, .ins_op, .ins_rd, .ins_rs1, .ins_rs2,
    .ins_size, .ins_opnd, .ins_csr, .irq, .br_resolve, .br_mispredict, .br_cond, .br_taken,
    .br_pc, .br_target, .fetch_take, .fetch_hit, .pred_cond, .pred_call, .pred_ret,
    .btb_hit, .btb_target, .fill_valid, .ins_ready, .issue_fire, .trap, .trap_cause,
    .fetch_addr, .fetch_zero, .icache_flush, .fill_req, .fill_addr, .store_commit,
    .store_addr, .csr_rdata);
  ipc_imem_model imem (.clk, .rst, .fill_req, .fill_valid);

  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Event monitor; sampling at the falling edge keeps it clear of the update edge.
  always @(negedge clk) begin
    cyc++;
    if (issue_fire === 1'b1) fires.push_back(cyc);
    if (trap === 1'b1) n_trap++;
    if (icache_flush === 1'b1) n_flush++;
    if (fill_req === 1'b1) n_fill++;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the offer until the slot takes it; the caller lowers ins_valid.
  task automatic offer(ipc_pkg::ipc_op_e op, logic [4:0] rs, logic [1:0] sz, logic [31:0] d,
                       logic [11:0] csr);
    ins_valid = 1'b1;
    ins_op = op;
    ins_rd = 5'h05;
    ins_rs1 = rs;
    ins_size = sz;
    ins_opnd = d;
    ins_csr = csr;
    for (int i = 0; i < 60 && ins_ready !== 1'b1; i++) @(negedge clk);
    check("slot ready", 32'h1, ins_ready);
    @(negedge clk);
  endtask

  // Producer then a consumer of its result; the issue spacing is the latency.
  task automatic gap(ipc_pkg::ipc_op_e op, logic [1:0] sz, logic [31:0] d, int exp);
    fires.delete();
    offer(op, 5'h00, sz, d, ipc_pkg::CSR_CYC);
    offer(ipc_pkg::OP_ALU, 5'h05, 2'h2, 32'h0, 12'h0);
    ins_valid = 1'b0;
    repeat (exp + 4) @(negedge clk);
    check("issue gap", exp, fires.size() == 2 ? fires[1] - fires[0] : -1);
  endtask

  task automatic trapcase(ipc_pkg::ipc_op_e op, logic [1:0] sz, logic [31:0] a,
                          logic [4:0] cause, logic [31:0] vec);
    int t0;
    t0 = n_trap;
    offer(op, 5'h00, sz, a, 12'h0);
    ins_valid = 1'b0;
    repeat (6) @(negedge clk);
    check("trap count", t0 + 1, n_trap);
    check("trap cause", cause, trap_cause);
    check("pc at vector", vec, fetch_addr);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang is cut off well past the few hundred cycles the sequence needs.
  initial begin
    #400000;
    n_fail++;
    end_sim();
  end

  initial begin
    {rst, ce, fetch_hit} = 3'b111;
    {ins_valid, irq, br_resolve, br_mispredict, br_cond, br_taken, fetch_take} = 7'h00;
    {pred_cond, pred_call, pred_ret, btb_hit, ins_rd, ins_rs1, ins_rs2, ins_size} = 21'h0;
    ins_op = ipc_pkg::OP_ALU;
    {ins_opnd, ins_csr, br_pc, br_target, btb_target} = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check("boot fetch", ipc_pkg::RESET_PC, fetch_addr);
    check("ready", 1, ins_ready);
    fetch_hit = 1'b0;
    fetch_take = 1'b1;
    repeat (10) @(negedge clk);
    fetch_hit = 1'b1;
    check("one fill", 1, n_fill);
    check("fill line", 32'h0000_1000, fill_addr);
    @(negedge clk);
    fetch_take = 1'b0;
    check("next word", 32'h0000_1004, fetch_addr);
    {br_resolve, br_mispredict, br_target} = {2'b11, 32'h4000_0000};
    @(negedge clk);
    {br_resolve, br_mispredict} = 2'b00;
    check("redirect", 32'h4000_0000, fetch_addr);
    fetch_hit = 1'b0;
    repeat (4) @(negedge clk);
    fetch_hit = 1'b1;
    check("no fetch trap fill", 1, n_fill);
    check("fetch cause", ipc_pkg::CAUSE_FETCH, trap_cause);
    check("zero page", 1, fetch_zero);
    gap(ipc_pkg::OP_ALU, 2'h2, 32'h8000_0000, 1);
    gap(ipc_pkg::OP_LOAD, 2'h2, 32'h8000_0000, 2);
    gap(ipc_pkg::OP_LOAD, 2'h0, 32'h8000_0003, 3);
    gap(ipc_pkg::OP_CSRR, 2'h2, 32'h0, 3);
    gap(ipc_pkg::OP_MUL, 2'h2, 32'h0, 5);
    gap(ipc_pkg::OP_DIV, 2'h2, 32'h0000_0001, 2);
    gap(ipc_pkg::OP_DIV, 2'h2, 32'h0000_0080, 9);
    gap(ipc_pkg::OP_DIV, 2'h2, 32'hffff_ffff, 33);
    trapcase(ipc_pkg::OP_LOAD, 2'h2, 32'h8000_0002, 5'h04, 32'h0);
    trapcase(ipc_pkg::OP_STORE, 2'h1, 32'h8000_0001, 5'h06, 32'h0);
    trapcase(ipc_pkg::OP_AMO, 2'h2, 32'h4000_0000, 5'h07, 32'h0);
    trapcase(ipc_pkg::OP_LR, 2'h2, 32'h8000_0000, 5'h05, 32'h0);
    trapcase(ipc_pkg::OP_SC, 2'h2, 32'h8000_0000, 5'h07, 32'h0);
    // The first read lands as the second is taken; the second waits out the read latency.
    offer(ipc_pkg::OP_CSRR, 5'h00, 2'h2, 32'h0, ipc_pkg::CSR_CYC);
    offer(ipc_pkg::OP_CSRR, 5'h00, 2'h2, 32'h0, ipc_pkg::CSR_CYC);
    v1 = csr_rdata;
    ins_valid = 1'b0;
    repeat (4) @(negedge clk);
    check("cycles rise", 32'h3, csr_rdata - v1);
    offer(ipc_pkg::OP_CSRR, 5'h00, 2'h2, 32'h0, ipc_pkg::CSR_RETH);
    ins_valid = 1'b0;
    repeat (4) @(negedge clk);
    check("retired high", 32'h0, csr_rdata);
    offer(ipc_pkg::OP_FENCEI, 5'h00, 2'h2, 32'h0, 12'h0);
    offer(ipc_pkg::OP_CSRW, 5'h00, 2'h2, 32'h0002_0000, ipc_pkg::CSR_TVEC);
    ins_valid = 1'b0;
    repeat (8) @(negedge clk);
    check("flush", 1, n_flush);
    trapcase(ipc_pkg::OP_LOAD, 2'h1, 32'h8000_0001, 5'h04, 32'h0002_0000);
    // Clock enable low must hold the fetch pc although a fetch is offered.
    {ce, fetch_take} = 2'b01;
    repeat (3) @(negedge clk);
    check("frozen pc", 32'h0002_0000, fetch_addr);
    {ce, fetch_take} = 2'b10;
    // An interrupt taken behind a divide must not shorten it for a dependent.
    fires.delete();
    offer(ipc_pkg::OP_DIV, 5'h00, 2'h2, 32'hffff_ffff, 12'h0);
    ins_valid = 1'b0;
    @(negedge clk);
    irq = 1'b1;
    @(negedge clk);
    irq = 1'b0;
    check("irq cause", ipc_pkg::CAUSE_IRQ, trap_cause);
    offer(ipc_pkg::OP_ALU, 5'h05, 2'h2, 32'h0, 12'h0);
    ins_valid = 1'b0;
    repeat (40) @(negedge clk);
    check("divide kept", 33, fires.size() == 2 ? fires[1] - fires[0] : -1);
    offer(ipc_pkg::OP_STORE, 5'h00, 2'h2, 32'h8000_0010, 12'h0);
    ins_valid = 1'b0;
    repeat (3) @(negedge clk);
    check("store commit", 32'h8000_0010, store_addr);
    end_sim();
  end
endmodule
